// >>> include/imlu_pkg.sv
// shared constants and types for the integer multiply and logic unit
package imlu_pkg;
    localparam int XLEN = 32;
    // primary and extended opcodes
    localparam logic [5:0] OPC_PRIMARY_X  = 6'h1F;
    localparam logic [5:0] OPC_MUL_IMM    = 6'h07;
    localparam logic [9:0] XO_SEG_WR      = 10'h0D2; // 210
    localparam logic [9:0] XO_SEG_WR_IND  = 10'h0F2; // 242
    localparam logic [8:0] XO_MUL_HI_S    = 9'h04B;  // 75
    localparam logic [8:0] XO_MUL_HI_U    = 9'h00B;  // 11
    localparam logic [8:0] XO_MUL_LO      = 9'h0EB;  // 235
    localparam logic [8:0] XO_NEG         = 9'h068;  // 104
    localparam logic [9:0] XO_NAND        = 10'h1DC; // 476
    localparam logic [9:0] XO_NOR         = 10'h07C; // 124
    localparam logic [9:0] XO_OR          = 10'h1BC; // 444
    // instruction field positions, bit 0 = least significant
    localparam int F_PRI_LSB  = 26;
    localparam int F_RT_LSB   = 21;
    localparam int F_RA_LSB   = 16;
    localparam int F_RB_LSB   = 11;
    localparam int F_SEG_LSB  = 16;
    localparam int F_OE_BIT   = 10;
    localparam int F_XO_LSB   = 1;
    localparam int F_RC_BIT   = 0;
    // exception register bit positions
    localparam int XER_SO_BIT = 31;
    localparam int XER_OV_BIT = 30;
    localparam int NUM_SEG    = 16;
    // register map of the status and control registers
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_IRQ_ST  = 8'h08;
    localparam logic [7:0] REG_IRQ_MSK = 8'h0C;
    localparam logic [7:0] REG_FXER    = 8'h10;
    localparam logic [7:0] REG_SEG_BASE = 8'h40;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
    localparam logic [31:0] FXER_RESET  = 32'h0000_0000;
    localparam logic [31:0] SEG_RESET   = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // interrupt status bits
    localparam int IRQ_PRIV   = 0;
    localparam int IRQ_OVF    = 1;
    localparam int IRQ_ILLEG  = 2;
    localparam int IRQ_W      = 3;
    typedef enum logic [3:0] {
        OP_NONE, OP_SEG, OP_SEG_IND, OP_MULHS, OP_MULHU, OP_MULI,
        OP_MULLW, OP_NEG, OP_NAND, OP_NOR, OP_OR, OP_ILLEGAL
    } imlu_op_t;
endpackage

// >>> rtl/imlu_exec.sv
// combinational datapath: operation result, overflow and compare field
`timescale 1ns/10ps
`default_nettype none
module imlu_exec (
    input  wire imlu_pkg::imlu_op_t op,
    input  wire logic [31:0] opa,
    input  wire logic [31:0] opb,
    input  wire logic [15:0] imm,
    input  wire logic        so_in,
    output logic [31:0]      result,
    output logic             ovf,
    output logic [3:0]       cmp_field
);
    import imlu_pkg::*;
    logic signed [63:0] prod_s;
    logic        [63:0] prod_u;
    logic signed [47:0] prod_i;
    assign prod_s = $signed(opa) * $signed(opb);
    assign prod_u = opa * opb;
    assign prod_i = $signed(opa) * $signed(imm);
    always_comb begin
        result = 32'h0000_0000;
        ovf    = 1'b0;
        case (op)
            OP_MULHS: result = prod_s[63:32];
            OP_MULHU: result = prod_u[63:32];
            OP_MULI:  result = prod_i[31:0];
            OP_MULLW: begin
                result = prod_u[31:0];
                ovf = (prod_s[63:31] != {33{prod_s[31]}});
            end
            OP_NEG: begin
                result = ~opa + 32'h0000_0001;
                ovf = (opa == 32'h8000_0000);
            end
            OP_NAND:  result = ~(opa & opb);
            OP_NOR:   result = ~(opa | opb);
            OP_OR:    result = opa | opb;
            default:  result = 32'h0000_0000;
        endcase
    end
    // signed test even for the unsigned high multiply
    always_comb begin
        cmp_field[3] = result[31];
        cmp_field[2] = !result[31] && (result != 32'h0000_0000);
        cmp_field[1] = (result == 32'h0000_0000);
        cmp_field[0] = so_in;
    end
endmodule
`default_nettype wire

// >>> rtl/imlu_top.sv
// integer multiply and logic unit with segment file and register slave
//
// Contract
// - direct segment write copies source into selected register
// - indirect write indexes by top four bits
// - segment writes allowed only in supervisor state
// - signed high multiply returns upper product half
// - unsigned high multiply, compare field stays signed
// - record bit updates compare field zero
// - immediate multiply keeps low 32, no flags
// - low multiply returns low product word
// - enabled overflow sets overflow and summary flags
// - negate is complement plus one
// - negating most negative returns it, overflows
// - nand complements the bitwise and
// - nor complements the bitwise or
// - or writes bitwise or
`timescale 1ns/10ps
`default_nettype none
module imlu_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // issue side
    input  wire logic        issue_valid,
    input  wire logic [31:0] insn,
    input  wire logic [31:0] first_operand_gpr,
    input  wire logic [31:0] second_operand_gpr,
    input  wire logic [31:0] source_gpr,
    output logic             done_valid,
    output logic             wb_en,
    output logic [4:0]       wb_index,
    output logic [31:0]      wb_data,
    output logic             cr0_wr,
    output logic [3:0]       compare_field_zero,
    output logic             priv_exception,
    output logic             illegal_exception,
    output logic             irq,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import imlu_pkg::*;

    logic [31:0]      ctrl_q;
    logic [31:0]      fixed_point_exception_reg_q;
    logic [31:0]      seg_q [NUM_SEG];
    logic [IRQ_W-1:0] irq_st_q;
    logic [IRQ_W-1:0] irq_msk_q;
    logic [31:0]      last_result_q;
    imlu_op_t         op;
    logic [31:0]      ex_result;
    logic             ex_ovf;
    logic [3:0]       ex_cmp;
    logic             record_bit;
    logic             oe_bit;
    logic             supervisor;
    logic             seg_op;
    logic             seg_fault;
    logic [3:0]       seg_idx;
    logic [31:0]      opa;
    logic             ovf_event;

    // one decode for all operations; unknown codes flag illegal
    function automatic imlu_op_t decode(input logic [31:0] i);
        imlu_op_t r;
        r = OP_ILLEGAL;
        if (i[31:F_PRI_LSB] == OPC_MUL_IMM) begin
            r = OP_MULI;
        end else if (i[31:F_PRI_LSB] == OPC_PRIMARY_X) begin
            case (i[F_XO_LSB +: 10])
                XO_SEG_WR:     r = OP_SEG;
                XO_SEG_WR_IND: r = OP_SEG_IND;
                XO_NAND:       r = OP_NAND;
                XO_NOR:        r = OP_NOR;
                XO_OR:         r = OP_OR;
                default: begin
                    case (i[F_XO_LSB +: 9])
                        XO_MUL_HI_S: r = OP_MULHS;
                        XO_MUL_HI_U: r = OP_MULHU;
                        XO_MUL_LO:   r = OP_MULLW;
                        XO_NEG:      r = OP_NEG;
                        default:     r = OP_ILLEGAL;
                    endcase
                end
            endcase
        end
        return r;
    endfunction

    assign op         = issue_valid ? decode(insn) : OP_NONE;
    assign record_bit = insn[F_RC_BIT] && (op != OP_MULI)
                        && (op != OP_SEG) && (op != OP_SEG_IND);
    assign oe_bit     = insn[F_OE_BIT] && ((op == OP_MULLW) || (op == OP_NEG));
    assign supervisor = ctrl_q[0];
    assign seg_op     = (op == OP_SEG) || (op == OP_SEG_IND);
    assign seg_fault  = seg_op && !supervisor;
    assign seg_idx    = (op == OP_SEG) ? insn[F_SEG_LSB +: 4]
                                       : second_operand_gpr[31:28];
    // logical ops read the source register, arithmetic the first operand
    assign opa = ((op == OP_NAND) || (op == OP_NOR) || (op == OP_OR))
                 ? source_gpr : first_operand_gpr;
    assign ovf_event = oe_bit && ex_ovf;

    imlu_exec u_exec (
        .op        (op),
        .opa       (opa),
        .opb       (second_operand_gpr),
        .imm       (insn[15:0]),
        .so_in     (fixed_point_exception_reg_q[XER_SO_BIT] || ovf_event),
        .result    (ex_result),
        .ovf       (ex_ovf),
        .cmp_field (ex_cmp)
    );

    // results register one cycle after issue
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_valid         <= 1'b0;
            wb_en              <= 1'b0;
            wb_index           <= 5'h00;
            wb_data            <= 32'h0000_0000;
            cr0_wr             <= 1'b0;
            compare_field_zero <= 4'h0;
            priv_exception     <= 1'b0;
            illegal_exception  <= 1'b0;
            last_result_q      <= 32'h0000_0000;
        end else begin
            done_valid        <= issue_valid;
            priv_exception    <= seg_fault;
            illegal_exception <= (op == OP_ILLEGAL);
            wb_en    <= issue_valid && !seg_op && (op != OP_ILLEGAL);
            wb_index <= (op == OP_NAND || op == OP_NOR || op == OP_OR)
                        ? insn[F_RA_LSB +: 5] : insn[F_RT_LSB +: 5];
            if (issue_valid && !seg_op && (op != OP_ILLEGAL)) begin
                wb_data       <= ex_result;
                last_result_q <= ex_result;
            end
            cr0_wr <= issue_valid && record_bit && (op != OP_ILLEGAL);
            if (issue_valid && record_bit && (op != OP_ILLEGAL)) begin
                compare_field_zero <= ex_cmp;
            end
        end
    end

    // segment register file
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < NUM_SEG; k++) begin
                seg_q[k] <= SEG_RESET;
            end
        end else if (seg_op && !seg_fault) begin
            seg_q[seg_idx] <= source_gpr;
        end
    end

    // axi4-lite write: accept address and data in either order
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        wr_hit;
    logic [31:0] wmask;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_hit  = (aw_addr_q == REG_CTRL) || (aw_addr_q == REG_IRQ_ST)
                     || (aw_addr_q == REG_IRQ_MSK) || (aw_addr_q == REG_FXER);
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{w_strb_q[b]}};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q    <= CTRL_RESET;
            irq_msk_q <= '0;
        end else if (wr_fire) begin
            if (aw_addr_q == REG_CTRL) begin
                ctrl_q <= (ctrl_q & ~wmask) | (w_data_q & wmask);
            end
            if (aw_addr_q == REG_IRQ_MSK) begin
                irq_msk_q <= (irq_msk_q & ~wmask[IRQ_W-1:0])
                             | (w_data_q[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
            end
        end
    end

    // only software may clear the summary bit; a new overflow wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fixed_point_exception_reg_q <= FXER_RESET;
        end else begin
            if (wr_fire && aw_addr_q == REG_FXER) begin
                fixed_point_exception_reg_q <=
                    (fixed_point_exception_reg_q & ~wmask)
                    | (w_data_q & wmask);
            end
            if (issue_valid && oe_bit) begin
                fixed_point_exception_reg_q[XER_OV_BIT] <= ex_ovf;
            end
            if (ovf_event) begin
                fixed_point_exception_reg_q[XER_SO_BIT] <= 1'b1;
            end
        end
    end

    // sticky events, write one to clear, set beats clear
    logic [IRQ_W-1:0] ev;
    assign ev = {op == OP_ILLEGAL, ovf_event, seg_fault};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_q <= '0;
        end else begin
            if (wr_fire && aw_addr_q == REG_IRQ_ST) begin
                irq_st_q <= (irq_st_q & ~(w_data_q[IRQ_W-1:0]
                            & wmask[IRQ_W-1:0])) | ev;
            end else begin
                irq_st_q <= irq_st_q | ev;
            end
        end
    end
    assign irq = |(irq_st_q & irq_msk_q);

    // axi4-lite read
    logic [7:0] ra;
    assign ra = {s_axi_araddr[7:2], 2'b00};
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (ra >= REG_SEG_BASE && ra < REG_SEG_BASE + 8'h40) begin
                s_axi_rdata <= seg_q[ra[5:2]];
            end else begin
                case (ra)
                    REG_CTRL:    s_axi_rdata <= ctrl_q;
                    REG_STATUS:  s_axi_rdata <= last_result_q;
                    REG_IRQ_ST:  s_axi_rdata <= {29'h0, irq_st_q};
                    REG_IRQ_MSK: s_axi_rdata <= {29'h0, irq_msk_q};
                    REG_FXER:    s_axi_rdata <= fixed_point_exception_reg_q;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> sim/imlu_gpr_model.sv
// register file model that catches the unit's write-backs
`timescale 1ns/10ps
`default_nettype none
module imlu_gpr_model (
    input wire logic        aclk,
    input wire logic        wb_en,
    input wire logic [4:0]  wb_index,
    input wire logic [31:0] wb_data
);
    // a stale pattern so a missing write-back never looks right
    logic [31:0] gpr [32];
    initial begin
        foreach (gpr[i]) gpr[i] = 32'hA5A5_A5A5;
    end
    always @(posedge aclk) begin
        if (wb_en) gpr[wb_index] <= wb_data;
    end
endmodule
`default_nettype wire

// >>> sim/imlu_monitor.sv
// port-level assertions for the integer multiply and logic unit
`timescale 1ns/10ps
`default_nettype none
module imlu_monitor
    import imlu_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        issue_valid,
    input wire logic [31:0] insn,
    input wire logic [31:0] first_operand_gpr,
    input wire logic [31:0] second_operand_gpr,
    input wire logic [31:0] source_gpr,
    input wire logic        done_valid,
    input wire logic        wb_en,
    input wire logic [4:0]  wb_index,
    input wire logic [31:0] wb_data,
    input wire logic        cr0_wr,
    input wire logic [3:0]  compare_field_zero,
    input wire logic        priv_exception
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       ext;
    logic [9:0] xo;
    assign ext = issue_valid && insn[31:26] == OPC_PRIMARY_X;
    assign xo  = insn[10:1];

    chk_done_after_issue: assert property (issue_valid |=> done_valid)
        else $error("no completion one cycle after issue");
    chk_no_stray_done: assert property (!issue_valid |=> !done_valid)
        else $error("completion without an issue");
    chk_seg_fault_cause: assert property (priv_exception |-> $past(ext) &&
        ($past(xo) == XO_SEG_WR || $past(xo) == XO_SEG_WR_IND))
        else $error("privilege fault without a segment write");
    chk_seg_no_wb: assert property ((ext && (xo == XO_SEG_WR ||
        xo == XO_SEG_WR_IND)) |=> !wb_en && !cr0_wr)
        else $error("segment write touched a general register");
    chk_or_result: assert property (ext && xo == XO_OR |=> wb_en &&
        wb_index == $past(insn[20:16]) &&
        wb_data == ($past(source_gpr) | $past(second_operand_gpr)))
        else $error("or result wrong");
    chk_nand_result: assert property (ext && xo == XO_NAND |=>
        wb_data == ~($past(source_gpr) & $past(second_operand_gpr)))
        else $error("nand result wrong");
    chk_nor_result: assert property (ext && xo == XO_NOR |=>
        wb_data == ~($past(source_gpr) | $past(second_operand_gpr)))
        else $error("nor result wrong");
    chk_imm_mul_low: assert property (issue_valid &&
        insn[31:26] == OPC_MUL_IMM |=> !cr0_wr && wb_data ==
        $past(first_operand_gpr) * {{16{$past(insn[15])}}, $past(insn[15:0])})
        else $error("immediate multiply wrong");
    chk_neg_twos: assert property (ext && xo[8:0] == XO_NEG |=>
        wb_data == ~$past(first_operand_gpr) + 32'h1)
        else $error("negate result wrong");
    chk_record_cr: assert property (ext && insn[0] && (xo == XO_OR ||
        xo == XO_NAND || xo == XO_NOR) |=> cr0_wr)
        else $error("record form left compare field alone");
    chk_cr_relation: assert property (cr0_wr |->
        $onehot(compare_field_zero[3:1]) && compare_field_zero[3] ==
        wb_data[31] && compare_field_zero[1] == (wb_data == 32'h0))
        else $error("compare field does not match result");

    cover property (priv_exception);
    cover property (cr0_wr && compare_field_zero[0]);
    cover property (cr0_wr && compare_field_zero[1]);
endmodule

bind imlu_top imlu_monitor i_imlu_monitor (
    .aclk, .aresetn, .issue_valid, .insn, .first_operand_gpr,
    .second_operand_gpr, .source_gpr, .done_valid, .wb_en, .wb_index,
    .wb_data, .cr0_wr, .compare_field_zero, .priv_exception
);
`default_nettype wire

// >>> sim/tb_imlu_top.sv
// self-checking bench for the integer multiply and logic unit
`timescale 1ns/10ps
`default_nettype none
module tb_imlu_top;
    import imlu_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0, issue_valid = 1'h0;
    logic [31:0] insn = 32'h0, first_operand_gpr = 32'h0;
    logic [31:0] second_operand_gpr = 32'h0, source_gpr = 32'h0;
    logic        done_valid, wb_en, cr0_wr, priv_exception;
    logic        illegal_exception, irq, dv, cw, pe, ie;
    logic [4:0]  wb_index;
    logic [31:0] wb_data, s_axi_rdata, s, b, r, a;
    logic [3:0]  compare_field_zero;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [63:0] p;
    logic [9:0]  lops [3] = '{XO_NAND, XO_NOR, XO_OR};
    int          num_errors = 0;
    int          checks_done = 0;

    imlu_top i_imlu_top (
        .aclk, .aresetn, .issue_valid, .insn, .first_operand_gpr,
        .second_operand_gpr, .source_gpr, .done_valid, .wb_en, .wb_index,
        .wb_data, .cr0_wr, .compare_field_zero, .priv_exception,
        .illegal_exception, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    imlu_gpr_model i_imlu_gpr_model (.aclk, .wb_en, .wb_index, .wb_data);

    initial begin
        forever #20 aclk = ~aclk;
    end

    task summarize;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] seen, want);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // ready and answer are sampled at the falling edge, where they are
    // settled, and acted on at the next rising edge
    task axi(input logic we, input logic [7:0] ad, input logic [31:0] d,
             input logic [1:0] er);
        logic        ra, rw, fin;
        logic [1:0]  rs;
        logic [31:0] rd;
        int          n;
        fin = 1'h0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_awvalid <= we;
        s_axi_wdata <= d;
        s_axi_wvalid <= we;
        s_axi_bready <= we;
        s_axi_araddr <= ad;
        s_axi_arvalid <= !we;
        s_axi_rready <= !we;
        while (!fin) begin
            @(negedge aclk);
            ra = we ? s_axi_awready : s_axi_arready;
            rw = s_axi_wready;
            fin = we ? s_axi_bvalid : s_axi_rvalid;
            rs = we ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge aclk);
            if (ra) begin
                s_axi_awvalid <= 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (rw) s_axi_wvalid <= 1'h0;
            if (++n > 100) begin
                num_errors++;
                $display("unexpected at %0t: bus wait ran out", $time);
                summarize();
            end
        end
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        chk(rs, er);
        if (!we) chk(rd, d);
    endtask

    task iss(input logic [31:0] i, x, y, z);
        @(posedge aclk);
        issue_valid <= 1'h1;
        insn <= i;
        first_operand_gpr <= x;
        second_operand_gpr <= y;
        source_gpr <= z;
        @(posedge aclk);
        issue_valid <= 1'h0;
        #1;
        dv = done_valid;
        cw = cr0_wr;
        pe = priv_exception;
        ie = illegal_exception;
        @(posedge aclk);
        #1;
        chk(dv, 1'h1);
    endtask

    function automatic logic [31:0] xi(input logic [9:0] x, input logic rc);
        return {OPC_PRIMARY_X, 15'h0C85, x, rc};
    endfunction

    function automatic logic [3:0] crx(input logic [31:0] v, input logic so);
        return {v[31], !v[31] && v != 32'h0, v == 32'h0, so};
    endfunction

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        axi(1'h0, REG_CTRL, CTRL_RESET, RESP_OKAY);
        axi(1'h0, REG_FXER, FXER_RESET, RESP_OKAY);
        axi(1'h0, 8'h20, 32'h0, RESP_SLVERR);
        axi(1'h1, REG_STATUS, 32'h1, RESP_SLVERR);
        // first operand carries a decoy: logic ops must not read it
        for (int k = 0; k < 6; k++) begin
            s = k < 3 ? 32'hF0F0_1234 : 32'h0;
            b = k < 3 ? 32'h0FF0_FFFF : 32'h0;
            r = k % 3 == 0 ? ~(s & b) : k % 3 == 1 ? ~(s | b) : s | b;
            iss(xi(lops[k % 3], 1'h1), 32'h5555_5555, b, s);
            chk(i_imlu_gpr_model.gpr[4], r);
            chk(cw, 1'h1);
            chk(compare_field_zero, crx(r, 1'h0));
        end
        a = 32'hFFFF_FFFE;
        b = 32'hF000_0001;
        p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
        iss(xi({1'h0, XO_MUL_HI_S}, 1'h1), a, b, 32'h0);
        chk(i_imlu_gpr_model.gpr[3], p[63:32]);
        chk(compare_field_zero, crx(p[63:32], 1'h0));
        p = {32'h0, a} * {32'h0, b};
        iss(xi({1'h0, XO_MUL_HI_U}, 1'h1), a, b, 32'h0);
        chk(i_imlu_gpr_model.gpr[3], p[63:32]);
        chk(compare_field_zero, crx(p[63:32], 1'h0));
        a = 32'h1234_5678;
        iss({OPC_MUL_IMM, 10'h064, 16'hFFFE}, a, 32'h0, 32'h0);
        chk(i_imlu_gpr_model.gpr[3], a * 32'hFFFF_FFFE);
        chk(cw, 1'h0);
        axi(1'h0, REG_FXER, 32'h0, RESP_OKAY);
        iss(xi({1'h1, XO_MUL_LO}, 1'h1), 32'hFFFF_FFFD, 32'h7, 32'h0);
        chk(i_imlu_gpr_model.gpr[3], 32'hFFFF_FFEB);
        axi(1'h0, REG_FXER, 32'h0, RESP_OKAY);
        iss(xi({1'h1, XO_MUL_LO}, 1'h1), 32'h0001_0000, 32'h0001_0000, 32'h0);
        chk(i_imlu_gpr_model.gpr[3], 32'h0);
        chk(compare_field_zero, 4'h3);
        axi(1'h0, REG_FXER, 32'hC000_0000, RESP_OKAY);
        iss(xi({1'h1, XO_MUL_LO}, 1'h0), 32'h2, 32'h3, 32'h0);
        axi(1'h0, REG_FXER, 32'h8000_0000, RESP_OKAY);
        iss(xi({1'h0, XO_NEG}, 1'h0), 32'h5, 32'h0, 32'h0);
        chk(i_imlu_gpr_model.gpr[3], 32'hFFFF_FFFB);
        axi(1'h1, REG_FXER, 32'h0, RESP_OKAY);
        iss(xi({1'h1, XO_NEG}, 1'h1), 32'h8000_0000, 32'h0, 32'h0);
        chk(i_imlu_gpr_model.gpr[3], 32'h8000_0000);
        chk(compare_field_zero, 4'h9);
        axi(1'h0, REG_FXER, 32'hC000_0000, RESP_OKAY);
        axi(1'h0, REG_STATUS, 32'h8000_0000, RESP_OKAY);
        iss(32'h0, 32'h0, 32'h0, 32'h0);
        chk(ie, 1'h1);
        iss({OPC_PRIMARY_X, 10'h069, 5'h0, XO_SEG_WR, 1'h0}, 32'h0, 32'h0,
            32'hCAFE_0009);
        axi(1'h0, REG_SEG_BASE + 8'h24, 32'hCAFE_0009, RESP_OKAY);
        iss(xi(XO_SEG_WR_IND, 1'h0), 32'h0, 32'hA000_0000, 32'h1234_000A);
        axi(1'h0, REG_SEG_BASE + 8'h28, 32'h1234_000A, RESP_OKAY);
        axi(1'h1, REG_CTRL, 32'h0, RESP_OKAY);
        iss({OPC_PRIMARY_X, 10'h069, 5'h0, XO_SEG_WR, 1'h0}, 32'h0, 32'h0,
            32'h0BAD_0000);
        chk(pe, 1'h1);
        axi(1'h0, REG_SEG_BASE + 8'h24, 32'hCAFE_0009, RESP_OKAY);
        chk(irq, 1'h0);
        // overflow and illegal events above have set their bits as well
        axi(1'h0, REG_IRQ_ST, 32'h7, RESP_OKAY);
        axi(1'h1, REG_IRQ_MSK, 32'h1, RESP_OKAY);
        chk(irq, 1'h1);
        axi(1'h1, REG_IRQ_ST, 32'h1, RESP_OKAY);
        chk(irq, 1'h0);
        summarize();
    end
endmodule
`default_nettype wire
